// ===== design/rsq_top.sv
// Reset sequence manager with AXI4-Lite option and status registers
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module rsq_top
	import rsq_pkg::*;
#(
	parameter int STAB_LONG = STAB_LONG_CYC
)
(
	input wire logic CLOCK_I, // Oscillator clock, 25 MHz
	input wire logic ARST_N_I, // Async reset, active low
	input wire logic RST_PIN_I, // Reset pin level
	output logic RST_PIN_O, // Reset pin drive value
	output logic RST_PIN_OE_O, // Reset pin pulled low when high
	input wire logic UVD_LOW_I, // Supply below threshold, async
	input wire logic WDG_UNDERFLOW_I, // Watchdog underflow pulse
	output logic CORE_RST_N_O, // Core reset, active low
	output logic VEC_FETCH_O, // Vector fetch phase
	output logic [15:0] VEC_ADDR_O, // Vector address
	output logic CORE_TICK_O, // Core clock enable pulse
	output logic [2:0] OSC_SRC_O, // Selected oscillator
	output logic OSC_RUN_O, // Oscillator enable
	input wire logic [7:0] S_AXI_AWADDR_I, // Write address
	input wire logic S_AXI_AWVALID_I, // Write address valid
	output logic S_AXI_AWREADY_O, // Write address ready
	input wire logic [31:0] S_AXI_WDATA_I, // Write data
	input wire logic [3:0] S_AXI_WSTRB_I, // Write strobes
	input wire logic S_AXI_WVALID_I, // Write data valid
	output logic S_AXI_WREADY_O, // Write data ready
	output logic [1:0] S_AXI_BRESP_O, // Write response
	output logic S_AXI_BVALID_O, // Write response valid
	input wire logic S_AXI_BREADY_I, // Write response ready
	input wire logic [7:0] S_AXI_ARADDR_I, // Read address
	input wire logic S_AXI_ARVALID_I, // Read address valid
	output logic S_AXI_ARREADY_O, // Read address ready
	output logic [31:0] S_AXI_RDATA_O, // Read data
	output logic [1:0] S_AXI_RRESP_O, // Read response
	output logic S_AXI_RVALID_O, // Read data valid
	input wire logic S_AXI_RREADY_I // Read data ready
);
	import rsq_pkg::*;

	if (STAB_LONG < STAB_SHORT_CYC || STAB_LONG >= (1 << CNT_W))
	begin : g_bad_stab
		$error("STAB_LONG out of range");
	end

	// Option and status storage
	logic [7:0] opt_reg;
	logic opt_lock_reg;
	logic [NUM_FLAGS-1:0] flag_reg;
	logic [NUM_FLAGS-1:0] flag_next;
	logic por_done_reg;

	// Synchronisers
	logic pin_s1_reg;
	logic pin_s2_reg;
	logic cap_s1_reg;
	logic cap_s2_reg;
	logic uvd_s1_reg;
	logic uvd_s2_reg;
	logic pin_cap_reg;
	logic cap_clr_reg;
	logic pin_async_n;

	// Sequencer
	rsq_state_t state_reg;
	rsq_state_t state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic drive_reg;
	logic drive_next;
	// Pin sync lags our own release by two cycles; judge the pin only after that
	logic [1:0] rel_dly_reg;
	logic core_tick;

	// Bus
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;

	function automatic logic ofs_hit(input logic [7:0] a, input logic [7:0] ofs);
		ofs_hit = (a[7:2] == ofs[7:2]);
	endfunction

	wire opt_long = opt_reg[OPT_LONG_STAB];
	wire opt_pll = opt_reg[OPT_PLL_EN];
	wire opt_uvd = opt_reg[OPT_UVD_EN];
	wire [2:0] opt_osc = opt_reg[OPT_OSC_LSB +: 3];

	wire req_ext = cap_s2_reg;
	wire req_uvd = opt_uvd & uvd_s2_reg;
	wire req_wdg = WDG_UNDERFLOW_I;
	wire any_req = req_ext | req_uvd | req_wdg;
	wire pin_high = pin_s2_reg;
	wire [CNT_W-1:0] stab_last = opt_long ? CNT_W'(STAB_LONG - 1) : CNT_W'(STAB_SHORT_CYC - 1);
	wire [CNT_W-1:0] out_last = CNT_W'(RST_OUT_CYC - 1);
	wire [CNT_W-1:0] fetch_last = CNT_W'(FETCH_CYC - 1);
	wire hold_done = (cnt_reg == out_last);
	wire in_hold = (state_reg == ST_HOLD);
	wire enter_hold = (state_reg != ST_HOLD) & any_req;

	// Bus decode
	wire wr_go = aw_held_reg & w_held_reg & ~S_AXI_BVALID_O;
	wire wr_opt = wr_go & ofs_hit(aw_addr_reg, OFS_OPTION);
	wire wr_stat = wr_go & ofs_hit(aw_addr_reg, OFS_STATUS);
	wire rd_go = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
	wire rd_opt = ofs_hit(S_AXI_ARADDR_I, OFS_OPTION);
	wire rd_stat = ofs_hit(S_AXI_ARADDR_I, OFS_STATUS);
	wire [31:0] opt_word = {opt_lock_reg, 23'h0, opt_reg};
	wire [31:0] stat_word = {19'h0, pin_high, 3'h0, flag_reg, 2'h0, state_reg};
	wire [31:0] rd_word = rd_opt ? opt_word : (rd_stat ? stat_word : 32'h0);
	wire [NUM_FLAGS-1:0] w1c = (wr_stat & w_strb_reg[0]) ? w_data_reg[ST_FLAG_LSB +: NUM_FLAGS]
		: {NUM_FLAGS{1'b0}};

	// Pin seen low or power applied; set without a clock so a halted part still resets
	assign pin_async_n = ARST_N_I & RST_PIN_I;

	always_ff @(posedge CLOCK_I or negedge pin_async_n)
	begin
		if (!pin_async_n)
			pin_cap_reg <= 1'b1;
		else if (cap_clr_reg)
			pin_cap_reg <= 1'b0;
	end

	always_ff @(posedge CLOCK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			cap_s1_reg <= 1'b1;
			cap_s2_reg <= 1'b1;
			uvd_s1_reg <= 1'b0;
			uvd_s2_reg <= 1'b0;
		end
		else
		begin
			pin_s1_reg <= RST_PIN_I;
			pin_s2_reg <= pin_s1_reg;
			cap_s1_reg <= pin_cap_reg;
			cap_s2_reg <= cap_s1_reg;
			uvd_s1_reg <= UVD_LOW_I;
			uvd_s2_reg <= uvd_s1_reg;
		end
	end

	// Sequencer next state
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		drive_next = drive_reg;
		case (state_reg)
			ST_HOLD:
			begin
				// Least-width drive after any request, kept while supply is low
				if (any_req & drive_reg & ~hold_done)
					cnt_next = cnt_reg + CNT_W'(1);
				else if (~hold_done)
					cnt_next = cnt_reg + CNT_W'(1);
				if (hold_done & ~req_uvd)
					drive_next = 1'b0;
				// Long external pulse keeps the pin low from outside; wait it out
				if (~drive_reg & pin_high & ~cap_s2_reg & ~req_uvd & ~req_wdg)
				begin
					state_next = ST_STAB;
					cnt_next = '0;
				end
			end
			ST_STAB:
			begin
				if (core_tick)
				begin
					if (cnt_reg == stab_last)
					begin
						state_next = ST_FETCH;
						cnt_next = '0;
					end
					else
						cnt_next = cnt_reg + CNT_W'(1);
				end
			end
			ST_FETCH:
			begin
				if (core_tick)
				begin
					if (cnt_reg == fetch_last)
						state_next = ST_RUN;
					else
						cnt_next = cnt_reg + CNT_W'(1);
				end
			end
			ST_RUN:
			begin
				cnt_next = '0;
			end
			default:
			begin
				state_next = ST_HOLD;
				cnt_next = '0;
			end
		endcase
		// Any fresh request outside the hold phase, running core included, restarts from the top
		if (enter_hold)
		begin
			state_next = ST_HOLD;
			cnt_next = '0;
			drive_next = 1'b1;
		end
	end

	// Cause flags: hardware set wins over a software clear in the same cycle
	always_comb
	begin
		flag_next = flag_reg & ~w1c;
		if (enter_hold & req_ext)
			flag_next[FLG_EXT] = 1'b1;
		if (enter_hold & req_wdg)
			flag_next[FLG_WDG] = 1'b1;
		if (req_uvd & ~por_done_reg)
			flag_next[FLG_POR] = 1'b1;
		if (enter_hold & req_uvd & por_done_reg)
			flag_next[FLG_DROP] = 1'b1;
		if (in_hold & rel_dly_reg[1] & cap_s2_reg & ~pin_high)
			flag_next[FLG_LONG] = 1'b1;
	end

	always_ff @(posedge CLOCK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			state_reg <= ST_HOLD;
			cnt_reg <= '0;
			drive_reg <= 1'b1;
			rel_dly_reg <= 2'h0;
			cap_clr_reg <= 1'b0;
			flag_reg <= NUM_FLAGS'(1 << FLG_POR);
			por_done_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			drive_reg <= drive_next;
			rel_dly_reg <= {rel_dly_reg[0], in_hold & ~drive_reg};
			cap_clr_reg <= in_hold & ~drive_reg & pin_high;
			flag_reg <= flag_next;
			if (state_reg == ST_STAB)
				por_done_reg <= 1'b1;
		end
	end

	// Registered outputs, taken from the next state so they match the phase
	always_ff @(posedge CLOCK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			RST_PIN_O <= 1'b0;
			RST_PIN_OE_O <= 1'b1;
			CORE_RST_N_O <= 1'b0;
			VEC_FETCH_O <= 1'b0;
			VEC_ADDR_O <= VEC_ADDR_LO;
		end
		else
		begin
			RST_PIN_O <= 1'b0;
			RST_PIN_OE_O <= drive_next;
			CORE_RST_N_O <= (state_next == ST_RUN);
			VEC_FETCH_O <= (state_next == ST_FETCH);
			VEC_ADDR_O <= (cnt_next == '0) ? VEC_ADDR_LO : VEC_ADDR_HI;
		end
	end

	// Options: the first accepted write with byte 0 strobed locks them, as a one-time setting
	always_ff @(posedge CLOCK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			opt_reg <= OPT_RESET;
			opt_lock_reg <= 1'b0;
		end
		else if (wr_opt & ~opt_lock_reg & w_strb_reg[0])
		begin
			opt_reg <= w_data_reg[7:0];
			opt_lock_reg <= 1'b1;
		end
	end

	// Write channel: address and data taken in either order
	always_ff @(posedge CLOCK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			S_AXI_AWREADY_O <= 1'b0;
			S_AXI_WREADY_O <= 1'b0;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O <= RESP_OKAY;
		end
		else
		begin
			S_AXI_AWREADY_O <= ~aw_held_reg & ~(S_AXI_AWVALID_I & S_AXI_AWREADY_O);
			S_AXI_WREADY_O <= ~w_held_reg & ~(S_AXI_WVALID_I & S_AXI_WREADY_O);
			if (S_AXI_AWVALID_I & S_AXI_AWREADY_O)
			begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I & S_AXI_WREADY_O)
			begin
				w_held_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA_I;
				w_strb_reg <= S_AXI_WSTRB_I;
			end
			if (wr_go)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O <= (wr_opt | wr_stat) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (S_AXI_BREADY_I)
				S_AXI_BVALID_O <= 1'b0;
		end
	end

	// Read channel: one read in flight
	always_ff @(posedge CLOCK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O <= 32'h0;
			S_AXI_RRESP_O <= RESP_OKAY;
		end
		else
		begin
			S_AXI_ARREADY_O <= ~S_AXI_RVALID_O & ~rd_go;
			if (rd_go)
			begin
				S_AXI_RVALID_O <= 1'b1;
				S_AXI_RDATA_O <= rd_word;
				S_AXI_RRESP_O <= (rd_opt | rd_stat) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (S_AXI_RREADY_I)
				S_AXI_RVALID_O <= 1'b0;
		end
	end

	rsq_clkgen u_clkgen
	(
		.clk_i(CLOCK_I),
		.arst_n_i(ARST_N_I),
		.pll_en_i(opt_pll),
		.osc_sel_i(opt_osc),
		.tick_o(core_tick),
		.osc_src_o(OSC_SRC_O),
		.osc_run_o(OSC_RUN_O)
	);

	// Core tick leaves the block through one more register here, a cycle after the clock generator's tick
	always_ff @(posedge CLOCK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			CORE_TICK_O <= 1'b0;
		else
			CORE_TICK_O <= core_tick;
	end
endmodule // rsq_top

// ===== design/rsq_pkg.sv
// Shared constants and types for the reset sequencer and clock select block
package rsq_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_MHZ = CLK_HZ / 1_000_000;
	// Least output pulse width of the reset pin, in ns
	localparam int RST_OUT_MIN_NS = 20000;
	localparam int RST_OUT_CYC = (RST_OUT_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int STAB_SHORT_CYC = 256;
	localparam int STAB_LONG_CYC = 4096;
	localparam int FETCH_CYC = 2;
	localparam int CNT_W = 13;
	localparam logic [15:0] VEC_ADDR_LO = 16'hfffe;
	localparam logic [15:0] VEC_ADDR_HI = 16'hffff;
	// Register map, byte addresses
	localparam logic [7:0] OFS_OPTION = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	// Option register fields
	localparam int OPT_LONG_STAB = 0;
	localparam int OPT_PLL_EN = 1;
	localparam int OPT_UVD_EN = 2;
	localparam int OPT_OSC_LSB = 4;
	localparam int OPT_LOCK = 31;
	localparam logic [7:0] OPT_RESET = 8'h04;
	// Status register fields
	localparam int ST_PHASE_LSB = 0;
	localparam int ST_FLAG_LSB = 4;
	localparam int ST_PIN = 12;
	localparam int NUM_FLAGS = 5;
	localparam int FLG_EXT = 0;
	localparam int FLG_POR = 1;
	localparam int FLG_DROP = 2;
	localparam int FLG_WDG = 3;
	localparam int FLG_LONG = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		OSC_EXT_CLK,
		OSC_RES_1,
		OSC_RES_2,
		OSC_RES_3,
		OSC_RES_4,
		OSC_RES_5,
		OSC_EXT_RC,
		OSC_INT_RC
	} rsq_osc_t;
	typedef enum logic [1:0] {
		ST_HOLD,
		ST_STAB,
		ST_FETCH,
		ST_RUN
	} rsq_state_t;
endpackage

// ===== design/rsq_clkgen.sv
// Core clock derivation: PLL doubling or divide by two, oscillator select
`timescale 1ns/1ps
module rsq_clkgen
	import rsq_pkg::*;
(
	input wire logic clk_i, // Oscillator clock
	input wire logic arst_n_i, // Async reset, active low
	input wire logic pll_en_i, // Doubling path chosen
	input wire logic [2:0] osc_sel_i, // Oscillator choice
	output logic tick_o, // One pulse per core clock cycle
	output logic [2:0] osc_src_o, // Selected source
	output logic osc_run_o // Oscillator enable
);
	logic div_reg;
	logic tick_next;

	// Doubled clock is twice the halved one: a core cycle every oscillator cycle
	assign tick_next = pll_en_i | div_reg;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			div_reg <= 1'b0;
			tick_o <= 1'b0;
			osc_src_o <= 3'h0;
			osc_run_o <= 1'b0;
		end
		else
		begin
			div_reg <= ~div_reg;
			tick_o <= tick_next;
			osc_src_o <= osc_sel_i;
			// Never stopped by a reset request, yet the stabilisation delay still runs at every release
			osc_run_o <= 1'b1;
		end
	end
endmodule // rsq_clkgen

// ===== dv/rsq_top_props.sv
// Checker of reset sequencing, vector fetch and write responses
`timescale 1ns/1ps
module rsq_top_props
	import rsq_pkg::*;
(
	input wire logic CLOCK_I, // Clock
	input wire logic ARST_N_I, // Reset, active low
	input wire logic RST_PIN_O, // Pin data
	input wire logic RST_PIN_OE_O, // Pin pulled low
	input wire logic WDG_UNDERFLOW_I, // Watchdog pulse
	input wire logic CORE_RST_N_O, // Core reset
	input wire logic VEC_FETCH_O, // Fetch phase
	input wire logic [15:0] VEC_ADDR_O, // Vector address
	input wire logic OSC_RUN_O, // Oscillator on
	input wire logic S_AXI_BVALID_O, // Write response valid
	input wire logic S_AXI_BREADY_I // Write response ready
);
	int oe_cnt_reg;
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!ARST_N_I);
	// Length of the current pin drive
	always_ff @(posedge CLOCK_I or negedge ARST_N_I)
		if (!ARST_N_I)
			oe_cnt_reg <= 0;
		else
			oe_cnt_reg <= RST_PIN_OE_O ? oe_cnt_reg + 1 : 0;
	AST_PIN_DATA: assert property (RST_PIN_O == 1'b0)
		else $error("pin data not low");
	AST_DELAY_HOLD: assert property (RST_PIN_OE_O |-> !CORE_RST_N_O && !VEC_FETCH_O)
		else $error("core active while pin driven");
	AST_WDG_START: assert property (WDG_UNDERFLOW_I && CORE_RST_N_O |=> RST_PIN_OE_O)
		else $error("watchdog did not drive pin");
	AST_OUT_WIDTH: assert property ($fell(RST_PIN_OE_O) |-> oe_cnt_reg >= RST_OUT_CYC - 1)
		else $error("pin drive too short");
	AST_FETCH_LO: assert property ($rose(VEC_FETCH_O) |-> VEC_ADDR_O == VEC_ADDR_LO ##1 VEC_FETCH_O)
		else $error("fetch start wrong");
	// A new request may cut a fetch short, so only a clean end is judged
	AST_FETCH_HI: assert property ($fell(VEC_FETCH_O) && !RST_PIN_OE_O |->
		$past(VEC_ADDR_O) == VEC_ADDR_HI && CORE_RST_N_O)
		else $error("fetch end wrong");
	AST_RUN_AFTER_FETCH: assert property ($rose(CORE_RST_N_O) |-> $past(VEC_FETCH_O))
		else $error("core released without fetch");
	AST_OSC_KEPT: assert property ($past(OSC_RUN_O) |-> OSC_RUN_O)
		else $error("oscillator stopped");
	AST_B_STANDS: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
		else $error("write response dropped");
endmodule // rsq_top_props
bind rsq_top rsq_top_props rsq_top_props_i (.*);

// ===== dv/rsq_pin_model.sv
// Board circuitry sharing the reset pin
`timescale 1ns/1ps
module rsq_pin_model
(
	input wire logic clk_i, // Clock
	input wire logic oe_i, // Device pulls low
	output logic pin_o // Pin level
);
	logic pull_reg = 1'b0;
	// Weak pull-up: low if any party pulls
	assign pin_o = (oe_i || pull_reg) ? 1'b0 : 1'b1;
	// Caller keeps n above the least input width
	task automatic press(input int n);
		pull_reg <= 1'b1;
		repeat (n) @(posedge clk_i);
		pull_reg <= 1'b0;
	endtask
endmodule // rsq_pin_model

// ===== dv/reset_sequence_and_clock_select_bench.sv
// Bench of the reset sequencer and clock select block
`timescale 1ns/1ps
module reset_sequence_and_clock_select_bench;
	import rsq_pkg::*;
	localparam int SL = 300; // Short long delay keeps the run brief
	logic clk = 1'b0, arst_n = 1'b0, uvd = 1'b0, wdg = 1'b0, awv = 1'b0, wv = 1'b0;
	logic brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, hold;
	logic pin, oe, core_n, fetch, tick, awr, wr_r, bv, arr, rv;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdata, r;
	logic [2:0] osc;
	logic [1:0] bresp, rresp;
	int bad_count = 0, checks = 0, cyc = 0, w, s, n;
	int plen[2] = '{10, 800};
	rsq_top #(.STAB_LONG(SL)) rsq_top_i (.CLOCK_I(clk), .ARST_N_I(arst_n), .RST_PIN_I(pin),
		.RST_PIN_O(), .RST_PIN_OE_O(oe), .UVD_LOW_I(uvd), .WDG_UNDERFLOW_I(wdg),
		.CORE_RST_N_O(core_n), .VEC_FETCH_O(fetch), .VEC_ADDR_O(), .CORE_TICK_O(tick),
		.OSC_SRC_O(osc), .OSC_RUN_O(), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
		.S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wr_r), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
		.S_AXI_BREADY_I(brdy), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rrdy));
	rsq_pin_model rsq_pin_model_i (.clk_i(clk), .oe_i(oe), .pin_o(pin));
	task automatic chk(input bit ok, input string m);
		checks++;
		if (!ok)
		begin
			bad_count++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		bit ta, tw;
		int t;
		ta = 0;
		tw = 0;
		t = 0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		while (!(ta && tw) && t < 50)
		begin
			@(posedge clk);
			t++;
			ta = ta || awr === 1'b1;
			tw = tw || wr_r === 1'b1;
			awv <= !ta;
			wv <= !tw;
		end
		do @(posedge clk); while (bv !== 1'b1 && ++t < 100);
		brdy <= 1'b0;
		chk(bresp === e, "write response");
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e);
		int t;
		t = 0;
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1 && ++t < 50);
		arv <= 1'b0;
		do @(posedge clk); while (rv !== 1'b1 && ++t < 100);
		d = rdata;
		rrdy <= 1'b0;
		chk(rresp === e, "read response");
		@(posedge clk);
	endtask
	// Pin drive length, then cycles from pin release to fetch
	task automatic seq(output int pw, output int sw);
		int t;
		pw = 0;
		sw = 0;
		t = 0;
		while (oe !== 1'b1 && t < 50) begin @(posedge clk); t++; end
		while (oe === 1'b1 && pw < 20000) begin @(posedge clk); pw++; end
		while (fetch !== 1'b1 && sw < 20000) begin @(posedge clk); sw++; end
		while (core_n !== 1'b1 && t < 100) begin @(posedge clk); t++; end
	endtask
	task automatic ticks(input int c, output int k);
		k = 0;
		repeat (c) begin @(posedge clk); k += (tick === 1'b1); end
	endtask
	task automatic flag(input int b);
		rd(OFS_STATUS, r, RESP_OKAY);
		chk(r[ST_FLAG_LSB + b] === 1'b1 && r[ST_FLAG_LSB + FLG_LONG] === (b == FLG_LONG), "flag");
		wr(OFS_STATUS, 32'h000001f0, RESP_OKAY);
	endtask
	task automatic pulse();
		wdg <= 1'b1;
		@(posedge clk);
		wdg <= 1'b0;
	endtask
	initial
		forever #20 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			bad_count++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		seq(w, s);
		chk(w >= RST_OUT_CYC, "power-on width");
		chk(s >= 2 * STAB_SHORT_CYC && s <= 2 * STAB_SHORT_CYC + 30, "short delay");
		flag(FLG_POR);
		rd(OFS_OPTION, r, RESP_OKAY);
		chk(r[7:0] === OPT_RESET, "option reset value");
		ticks(20, n);
		chk(n == 10, "halved clock");
		$display("test power_on done");
		wr(OFS_OPTION, 32'h00000017, RESP_OKAY);
		wr(OFS_OPTION, 32'h00000050, RESP_OKAY);
		rd(OFS_OPTION, r, RESP_OKAY);
		chk(r[6:0] === 7'h17 && r[OPT_LOCK] === 1'b1 && osc === OSC_RES_1, "option");
		ticks(20, n);
		chk(n == 20, "doubled clock");
		rd(8'h08, r, RESP_SLVERR);
		chk(r === 32'h0, "unmapped read");
		$display("test option done");
		pulse();
		seq(w, s);
		chk(w >= RST_OUT_CYC, "watchdog width");
		chk(s >= SL && s <= SL + 30, "long delay");
		flag(FLG_WDG);
		$display("test watchdog done");
		foreach (plen[i])
		begin
			n = cyc;
			fork
				rsq_pin_model_i.press(plen[i]);
			join_none
			seq(w, s);
			chk(w >= RST_OUT_CYC && cyc - n >= plen[i] + SL, "external");
			flag(i ? FLG_LONG : FLG_EXT);
		end
		$display("test external done");
		uvd <= 1'b1;
		hold = 1'b0;
		repeat (5) @(posedge clk);
		repeat (700) begin @(posedge clk); hold = hold || oe !== 1'b1 || core_n !== 1'b0; end
		chk(!hold, "undervoltage hold");
		uvd <= 1'b0;
		seq(w, s);
		chk(s >= SL && s <= SL + 30, "after undervoltage");
		flag(FLG_DROP);
		pulse();
		repeat (RST_OUT_CYC + 40) @(posedge clk);
		chk(oe === 1'b0 && core_n === 1'b0, "in delay");
		pulse();
		@(posedge clk);
		chk(oe === 1'b1, "restart");
		seq(w, s);
		// The drive cycle seen by the restart check counts towards the width
		chk(w + 1 >= RST_OUT_CYC, "restart width");
		$display("test undervoltage_restart done");
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		seq(w, s);
		wr(OFS_OPTION, 32'h0, RESP_OKAY);
		uvd <= 1'b1;
		ticks(20, n);
		chk(oe === 1'b0 && core_n === 1'b1 && n == 10, "undervoltage off");
		uvd <= 1'b0;
		$display("test option_reset done");
		wrap_up();
	end
endmodule // reset_sequence_and_clock_select_bench
